// file: logic/occ_console.sv
// operator console control: register display, lamps, modes and manual controls
`timescale 1ns/1ps
// How it works
// - one of eighteen registers shown by switch
// - display bit 36 as sign, 37 parity
// - bad opcode lamp on unassigned opcode
// - bad memory lamp on missing bank
// - memory parity lamp on even readout parity
// - comm parity lamp on even converter parity
// - four alarm flags, set by write, cleared
// - computing lamps complementary from halt flop
// - sense and special flops in split form
// - run continues until stopped; clears step modes
// - one-instruction mode stops after each instruction
// - single-pulse mode gives one pulse per press
// - monitor mode halts when address matches pc
// - start at switch address or at pc
// - tape boots load three reserved words
// - readout fetches switch address to memory output
// - load word writes switches; manual executes them
// - repeat re-executes instruction without fetch
// - halt after instruction, finishing io
// - emergency halt stops io now
// - stop-on-error chooses halt or continue
// - clear controls reset flops, not memory
module occ_console
  import occ_pkg::*;
#(
  parameter int unsigned NUM_BANKS = 8
) (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  input  wire logic [OCC_NUM_REGS-1:0]  i_reg_select_switch,
  input  wire logic [OCC_WORD_W-1:0]    i_reg_values [OCC_NUM_REGS],
  input  wire logic                     i_run_switch,
  input  wire logic                     i_one_instr_switch,
  input  wire logic                     i_single_pulse_switch,
  input  wire logic                     i_address_match_stop_switch,
  input  wire logic                     i_stop_on_error_select,
  input  wire logic                     i_start_at_switch_address_button,
  input  wire logic                     i_start_at_pc_button,
  input  wire logic                     i_tape_boot_button,
  input  wire logic                     i_magtape_boot_button,
  input  wire logic                     i_readout_button,
  input  wire logic                     i_manual_exec_button,
  input  wire logic                     i_load_word_button,
  input  wire logic                     i_repeat_button,
  input  wire logic                     i_halt_button,
  input  wire logic                     i_emergency_stop_button,
  input  wire logic                     i_clear_error_button,
  input  wire logic                     i_clear_machine_button,
  input  wire logic                     i_clear_alarm_button,
  input  wire logic [OCC_ADDR_W-1:0]    i_address_switch_bank,
  input  wire logic [OCC_WORD_W-1:0]    i_word_switch_bank,
  input  wire occ_cpu_stat_t            i_cpu_stat,
  input  wire logic [OCC_NUM_ALARM-1:0] i_alarm_loc_write,
  input  wire logic [OCC_NUM_SENSE-1:0] i_sense_ff,
  input  wire logic [OCC_NUM_SPEC-1:0]  i_special_ff,
  output occ_cpu_req_t                  o_cpu_req,
  output logic                          o_cpu_timing_pulse,
  output logic                          o_cpu_pulse_inhibit,
  output logic                          o_cpu_skip_fetch,
  output logic                          o_cpu_abort_io,
  output logic                          o_clear_all_flops,
  output logic [OCC_WORD_W-1:0]         o_bus_display,
  output logic                          o_bus_display_blank,
  output logic                          o_sign_minus,
  output logic                          o_parity_digit,
  output logic                          o_bad_opcode_lamp,
  output logic                          o_bad_memory_lamp,
  output logic                          o_mem_parity_lamp,
  output logic                          o_comm_parity_lamp,
  output logic [OCC_NUM_ALARM-1:0]      o_alarm_lamps,
  output logic                          o_computing_lamp,
  output logic                          o_non_computing_lamp,
  output logic [OCC_NUM_SENSE-1:0]      o_sense_ff_lamps_set,
  output logic [OCC_NUM_SENSE-1:0]      o_sense_ff_lamps_reset,
  output logic [OCC_NUM_SPEC-1:0]       o_special_ff_lamps_set,
  output logic [OCC_NUM_SPEC-1:0]       o_special_ff_lamps_reset
);

  initial begin
    if (NUM_BANKS < 1 || NUM_BANKS > (1 << OCC_BANK_W))
      $error("occ_console: NUM_BANKS out of range");
  end

  localparam int unsigned LVL_W = OCC_NUM_REGS + 5;

  typedef struct packed {
    occ_state_t                 state;
    occ_cpu_req_t               req;
    logic                       pulse;
    logic                       inhibit;
    logic                       skip_fetch;
    logic                       abort_io;
    logic                       clear_all;
    logic                       halt_pending;
    logic                       error_stop;
    logic [OCC_WORD_W-1:0]      disp;
    logic                       blank;
    logic                       sign_minus;
    logic                       parity;
    logic                       bad_op;
    logic                       bad_mem;
    logic                       mem_par;
    logic                       comm_par;
    logic [OCC_NUM_ALARM-1:0]   alarm;
    logic                       halt_ff;
    logic                       computing;
    logic [OCC_NUM_SENSE-1:0]   sense;
    logic [OCC_NUM_SENSE-1:0]   sense_n;
    logic [OCC_NUM_SPEC-1:0]    spec;
    logic [OCC_NUM_SPEC-1:0]    spec_n;
  } occ_st_t;

  occ_st_t st_r;
  occ_st_t st_nxt;

  logic [LVL_W-1:0]          lvl_async;
  logic [LVL_W-1:0]          lvl;
  logic [OCC_NUM_BTN-1:0]    btn_async;
  logic [OCC_NUM_BTN-1:0]    btn;
  logic [OCC_NUM_REGS-1:0]   sel;
  logic                      run_mode;
  logic                      one_instr;
  logic                      single_pulse;
  logic                      monitor;
  logic                      stop_on_err;

  assign lvl_async = {i_reg_select_switch, i_run_switch, i_one_instr_switch,
                      i_single_pulse_switch, i_address_match_stop_switch,
                      i_stop_on_error_select};
  assign btn_async = {i_clear_alarm_button, i_clear_machine_button,
                      i_clear_error_button, i_emergency_stop_button,
                      i_halt_button, i_repeat_button, i_load_word_button,
                      i_manual_exec_button, i_readout_button,
                      i_magtape_boot_button, i_tape_boot_button,
                      i_start_at_pc_button, i_start_at_switch_address_button};

  occ_sync #(.WIDTH(LVL_W)) u_lvl_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    (lvl_async),
    .o_level    (lvl),
    .o_rise     ()
  );

  occ_sync #(.WIDTH(OCC_NUM_BTN)) u_btn_sync (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_async    (btn_async),
    .o_level    (),
    .o_rise     (btn)
  );

  assign sel          = lvl[LVL_W-1:5];
  // run releases the stepping selections
  assign run_mode     = lvl[4];
  assign one_instr    = lvl[3] & ~run_mode;
  assign single_pulse = lvl[2] & ~run_mode;
  assign monitor      = lvl[1];
  assign stop_on_err  = lvl[0];

  function automatic occ_cpu_req_t mk_req(input occ_cmd_t c,
                                           input logic [OCC_ADDR_W-1:0] a,
                                           input logic [OCC_WORD_W-1:0] w);
    occ_cpu_req_t r;
    r.cmd   = c;
    r.addr  = a;
    r.word  = w;
    r.valid = 1'b1;
    return r;
  endfunction : mk_req

  always_comb begin
    logic any_err;
    st_nxt           = st_r;
    any_err          = 1'b0;
    st_nxt.req       = '0;
    st_nxt.pulse     = 1'b0;
    st_nxt.abort_io  = 1'b0;
    st_nxt.clear_all = 1'b0;

    // lowest set select wins; none blanks
    st_nxt.blank = 1'b1;
    st_nxt.disp  = '0;
    for (int i = OCC_NUM_REGS - 1; i >= 0; i--) begin
      if (sel[i]) begin
        st_nxt.disp  = i_reg_values[i];
        st_nxt.blank = 1'b0;
      end
    end
    st_nxt.sign_minus = st_nxt.disp[OCC_SIGN_BIT];
    st_nxt.parity     = st_nxt.disp[OCC_PARITY_BIT];

    st_nxt.bad_op   = ~i_cpu_stat.opcode_valid;
    st_nxt.bad_mem  = (32'(i_cpu_stat.bank_ext) >= NUM_BANKS);
    st_nxt.mem_par  = occ_even_parity(i_cpu_stat.mem_out);
    if (i_cpu_stat.comm_valid) begin
      st_nxt.comm_par = occ_even_parity(i_cpu_stat.comm_word);
    end
    any_err = st_nxt.bad_op | st_nxt.bad_mem | st_nxt.mem_par | st_nxt.comm_par
              | i_cpu_stat.ext_error;

    // alarm flags: a write in the clear cycle still sets
    if (btn[OCC_BTN_CLR_ALARM]) begin
      st_nxt.alarm = '0;
    end
    st_nxt.alarm = st_nxt.alarm | i_alarm_loc_write;

    // split flip-flop indicators
    st_nxt.sense = i_sense_ff;
    st_nxt.spec  = i_special_ff;

    st_nxt.inhibit = single_pulse;

    if (btn[OCC_BTN_HALT] || btn[OCC_BTN_EHALT]) begin
      st_nxt.halt_pending = 1'b1;
    end

    unique case (st_r.state)
      OCC_ST_HALTED: begin
        st_nxt.halt_ff    = 1'b1;
        st_nxt.skip_fetch = 1'b0;
        st_nxt.halt_pending = 1'b0;
        if (btn[OCC_BTN_START_ASR]) begin
          st_nxt.req = mk_req(OCC_CMD_START_ASR, i_address_switch_bank, '0);
        end else if (btn[OCC_BTN_START_PC]) begin
          st_nxt.req = mk_req(OCC_CMD_START_PC, i_cpu_stat.pc, '0);
        end else if (btn[OCC_BTN_TAPE]) begin
          st_nxt.req = mk_req(OCC_CMD_BOOT_TAPE, '0, OCC_WORD_W'(OCC_BOOT_WORDS));
        end else if (btn[OCC_BTN_MAGTAPE]) begin
          st_nxt.req = mk_req(OCC_CMD_BOOT_MAG, '0, OCC_WORD_W'(OCC_BOOT_WORDS));
        end else if (btn[OCC_BTN_READOUT]) begin
          st_nxt.req = mk_req(OCC_CMD_READOUT, i_address_switch_bank, '0);
        end else if (btn[OCC_BTN_LOADWORD]) begin
          st_nxt.req = mk_req(OCC_CMD_LOADWORD, i_address_switch_bank,
                              i_word_switch_bank);
        end else if (btn[OCC_BTN_MANUAL]) begin
          st_nxt.req = mk_req(OCC_CMD_MANUAL, '0, i_word_switch_bank);
        end else if (btn[OCC_BTN_REPEAT]) begin
          st_nxt.req = mk_req(OCC_CMD_REPEAT, '0, '0);
          st_nxt.skip_fetch = 1'b1;
        end
        // starts and runs begin computing; transfers stay halted
        if (st_nxt.req.valid && st_nxt.req.cmd inside {OCC_CMD_START_ASR, OCC_CMD_START_PC,
            OCC_CMD_REPEAT, OCC_CMD_MANUAL}) begin
          st_nxt.halt_ff = 1'b0;
          st_nxt.state   = OCC_ST_RUNNING;
          st_nxt.pulse   = single_pulse;
        end
      end
      OCC_ST_RUNNING: begin
        // one pulse per initiating press
        if (single_pulse && (btn[OCC_BTN_START_PC] || btn[OCC_BTN_START_ASR])) begin
          st_nxt.pulse = 1'b1;
        end
        if (i_cpu_stat.prog_halt) begin
          st_nxt.state   = OCC_ST_HALTED;
          st_nxt.halt_ff = 1'b1;
        end else if (any_err && stop_on_err) begin
          st_nxt.state   = OCC_ST_HALTED;
          st_nxt.halt_ff = 1'b1;
        end else if (monitor && i_cpu_stat.pc == i_address_switch_bank) begin
          st_nxt.state   = OCC_ST_HALTED;
          st_nxt.halt_ff = 1'b1;
        end else if (st_nxt.halt_pending || one_instr) begin
          st_nxt.state = OCC_ST_DRAIN;
        end
      end
      OCC_ST_DRAIN: begin
        // io in progress is let run to completion
        if (i_cpu_stat.instr_done && !i_cpu_stat.io_active) begin
          st_nxt.state   = OCC_ST_HALTED;
          st_nxt.halt_ff = 1'b1;
        end
      end
      default: begin
        st_nxt.state   = OCC_ST_HALTED;
        st_nxt.halt_ff = 1'b1;
      end
    endcase

    if (st_r.state != OCC_ST_HALTED && btn[OCC_BTN_EHALT] && i_cpu_stat.io_active) begin
      st_nxt.abort_io = 1'b1;
      st_nxt.state    = OCC_ST_HALTED;
      st_nxt.halt_ff  = 1'b1;
    end

    // clears reset console flops; memory-held registers untouched
    if (btn[OCC_BTN_CLR_ERR] || btn[OCC_BTN_CLR_MACH]) begin
      st_nxt.clear_all    = 1'b1;
      st_nxt.state        = OCC_ST_HALTED;
      st_nxt.halt_ff      = 1'b1;
      st_nxt.halt_pending = 1'b0;
      st_nxt.skip_fetch   = 1'b0;
      st_nxt.req          = '0;
      st_nxt.pulse        = 1'b0;
    end
    st_nxt.computing = ~st_nxt.halt_ff;
    st_nxt.sense_n   = ~i_sense_ff;
    st_nxt.spec_n    = ~i_special_ff;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r         <= '0;
      st_r.state   <= OCC_ST_HALTED;
      st_r.halt_ff <= 1'b1;
      st_r.blank   <= 1'b1;
      st_r.sense_n <= '1;
      st_r.spec_n  <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_cpu_req                = st_r.req;
  assign o_cpu_timing_pulse       = st_r.pulse;
  assign o_cpu_pulse_inhibit      = st_r.inhibit;
  assign o_cpu_skip_fetch         = st_r.skip_fetch;
  assign o_cpu_abort_io           = st_r.abort_io;
  assign o_clear_all_flops        = st_r.clear_all;
  assign o_bus_display            = st_r.disp;
  assign o_bus_display_blank      = st_r.blank;
  assign o_sign_minus             = st_r.sign_minus;
  assign o_parity_digit           = st_r.parity;
  assign o_bad_opcode_lamp        = st_r.bad_op;
  assign o_bad_memory_lamp        = st_r.bad_mem;
  assign o_mem_parity_lamp        = st_r.mem_par;
  assign o_comm_parity_lamp       = st_r.comm_par;
  assign o_alarm_lamps            = st_r.alarm;
  assign o_computing_lamp         = st_r.computing;
  assign o_non_computing_lamp     = st_r.halt_ff;
  assign o_sense_ff_lamps_set     = st_r.sense;
  assign o_sense_ff_lamps_reset   = st_r.sense_n;
  assign o_special_ff_lamps_set   = st_r.spec;
  assign o_special_ff_lamps_reset = st_r.spec_n;

endmodule : occ_console

// file: logic/occ_pkg.sv
// shared types and constants for the operator console control block
package occ_pkg;

  localparam int unsigned OCC_NUM_REGS   = 18;
  localparam int unsigned OCC_WORD_W     = 38;
  localparam int unsigned OCC_ADDR_W     = 18;
  localparam int unsigned OCC_OP_W       = 6;
  localparam int unsigned OCC_OP_LSB     = 31;
  localparam int unsigned OCC_SIGN_BIT   = 36;
  localparam int unsigned OCC_PARITY_BIT = 37;
  localparam int unsigned OCC_BANK_W     = 3;
  localparam int unsigned OCC_BANK_LSB   = 14;
  localparam int unsigned OCC_NUM_SENSE  = 16;
  localparam int unsigned OCC_NUM_SPEC   = 7;
  localparam int unsigned OCC_NUM_ALARM  = 4;
  localparam int unsigned OCC_NUM_BTN    = 13;

  // button indices within the synchronised button vector
  localparam int unsigned OCC_BTN_START_ASR = 0;
  localparam int unsigned OCC_BTN_START_PC  = 1;
  localparam int unsigned OCC_BTN_TAPE      = 2;
  localparam int unsigned OCC_BTN_MAGTAPE   = 3;
  localparam int unsigned OCC_BTN_READOUT   = 4;
  localparam int unsigned OCC_BTN_MANUAL    = 5;
  localparam int unsigned OCC_BTN_LOADWORD  = 6;
  localparam int unsigned OCC_BTN_REPEAT    = 7;
  localparam int unsigned OCC_BTN_HALT      = 8;
  localparam int unsigned OCC_BTN_EHALT     = 9;
  localparam int unsigned OCC_BTN_CLR_ERR   = 10;
  localparam int unsigned OCC_BTN_CLR_MACH  = 11;
  localparam int unsigned OCC_BTN_CLR_ALARM = 12;

  // number of built-in read words loaded by a boot
  localparam logic [1:0] OCC_BOOT_WORDS = 2'h3;

  typedef enum logic [3:0] {
    OCC_CMD_NONE      = 4'h0,
    OCC_CMD_START_ASR = 4'h1,
    OCC_CMD_START_PC  = 4'h2,
    OCC_CMD_BOOT_TAPE = 4'h3,
    OCC_CMD_BOOT_MAG  = 4'h4,
    OCC_CMD_READOUT   = 4'h5,
    OCC_CMD_MANUAL    = 4'h6,
    OCC_CMD_LOADWORD  = 4'h7,
    OCC_CMD_REPEAT    = 4'h8
  } occ_cmd_t;

  typedef enum logic [1:0] {
    OCC_ST_HALTED  = 2'b00,
    OCC_ST_RUNNING = 2'b01,
    OCC_ST_DRAIN   = 2'b10
  } occ_state_t;

  // status coming back from the processor
  typedef struct packed {
    logic [OCC_WORD_W-1:0] instr;
    logic [OCC_ADDR_W-1:0] pc;
    logic [OCC_BANK_W-1:0] bank_ext;
    logic [OCC_WORD_W-1:0] mem_out;
    logic [OCC_WORD_W-1:0] comm_word;
    logic                  comm_valid;
    logic                  instr_done;
    logic                  io_active;
    logic                  prog_halt;
    logic                  opcode_valid;
    logic                  ext_error;
  } occ_cpu_stat_t;

  // request to the processor
  typedef struct packed {
    occ_cmd_t              cmd;
    logic [OCC_ADDR_W-1:0] addr;
    logic [OCC_WORD_W-1:0] word;
    logic                  valid;
  } occ_cpu_req_t;

  function automatic logic occ_even_parity(input logic [OCC_WORD_W-1:0] w);
    return ~(^w);
  endfunction : occ_even_parity

endpackage : occ_pkg

// file: logic/occ_sync.sv
// three-stage input synchroniser with agreement-based change detection
`timescale 1ns/1ps
module occ_sync
  import occ_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_rise
);

  initial begin
    if (WIDTH < 1) $error("occ_sync: WIDTH below 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] rise;
  } occ_sync_st_t;

  occ_sync_st_t st_r;
  occ_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // a change only counts when stages two and three agree
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
      end
    end
    st_nxt.rise = st_nxt.lvl & ~st_r.lvl;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.lvl;
  assign o_rise  = st_r.rise;

endmodule : occ_sync

// file: testbench/occ_console_properties.sv
// concurrent checks on the operator console ports
`timescale 1ns/1ps
module occ_console_properties
  import occ_pkg::*;
#(
  parameter int unsigned NUM_BANKS = 8
) (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  input  wire logic [OCC_ADDR_W-1:0]    i_address_switch_bank,
  input  wire occ_cpu_stat_t            i_cpu_stat,
  input  wire occ_cpu_req_t             o_cpu_req,
  input  wire logic                     o_clear_all_flops,
  input  wire logic                     o_cpu_abort_io,
  input  wire logic [OCC_WORD_W-1:0]    o_bus_display,
  input  wire logic                     o_bus_display_blank,
  input  wire logic                     o_sign_minus,
  input  wire logic                     o_parity_digit,
  input  wire logic                     o_bad_opcode_lamp,
  input  wire logic                     o_bad_memory_lamp,
  input  wire logic                     o_mem_parity_lamp,
  input  wire logic                     o_computing_lamp,
  input  wire logic                     o_non_computing_lamp,
  input  wire logic [OCC_NUM_SENSE-1:0] o_sense_ff_lamps_set,
  input  wire logic [OCC_NUM_SENSE-1:0] o_sense_ff_lamps_reset
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  chk_lamp_pair: assert property (o_computing_lamp != o_non_computing_lamp)
    else $error("lamp pair");
  chk_sense_split: assert property (o_sense_ff_lamps_set == ~o_sense_ff_lamps_reset)
    else $error("sense split");
  chk_opcode_lamp: assert property ($past(i_rst_n) |->
    o_bad_opcode_lamp == !$past(i_cpu_stat.opcode_valid)) else $error("opcode lamp");
  chk_bank_lamp: assert property ($past(i_rst_n) |->
    o_bad_memory_lamp == ($past(i_cpu_stat.bank_ext) >= NUM_BANKS)) else $error("bank lamp");
  chk_parity_lamp: assert property ($past(i_rst_n) |->
    o_mem_parity_lamp == ~^$past(i_cpu_stat.mem_out)) else $error("parity lamp");
  chk_req_single: assert property (o_cpu_req.valid |=> !o_cpu_req.valid)
    else $error("req width");
  chk_boot_count: assert property (o_cpu_req.valid &&
    o_cpu_req.cmd inside {OCC_CMD_BOOT_TAPE, OCC_CMD_BOOT_MAG} |->
    o_cpu_req.word == OCC_WORD_W'(OCC_BOOT_WORDS)) else $error("boot count");
  chk_switch_addr: assert property (o_cpu_req.valid &&
    o_cpu_req.cmd inside {OCC_CMD_START_ASR, OCC_CMD_READOUT, OCC_CMD_LOADWORD} |->
    o_cpu_req.addr == $past(i_address_switch_bank)) else $error("req address");
  chk_display_bits: assert property (o_sign_minus == o_bus_display[OCC_SIGN_BIT] &&
    o_parity_digit == o_bus_display[OCC_PARITY_BIT] &&
    (!o_bus_display_blank || o_bus_display == '0)) else $error("display bits");
  chk_abort_halts: assert property (o_cpu_abort_io |=> !o_cpu_abort_io && o_non_computing_lamp)
    else $error("abort halt");
  chk_clear_halts: assert property (o_clear_all_flops |-> ##[0:1] o_non_computing_lamp)
    else $error("clear halt");
  cover property (o_cpu_req.valid && o_cpu_req.cmd == OCC_CMD_REPEAT);
  cover property (o_cpu_abort_io);
  cover property ($fell(o_computing_lamp));
endmodule : occ_console_properties

bind occ_console occ_console_properties #(.NUM_BANKS(NUM_BANKS)) occ_console_properties_i (.*);

// file: testbench/occ_console_tb.sv
// self-checking bench for the operator console control block
`timescale 1ns/1ps
module occ_console_tb
  import occ_pkg::*;
;
  localparam int unsigned NB = 5;
  logic i_core_clk, i_rst_n, i_run_switch, i_one_instr_switch, i_single_pulse_switch;
  logic i_address_match_stop_switch, i_stop_on_error_select;
  logic [12:0] btn;
  wire i_start_at_switch_address_button = btn[0], i_start_at_pc_button = btn[1],
    i_tape_boot_button = btn[2], i_magtape_boot_button = btn[3], i_readout_button = btn[4],
    i_manual_exec_button = btn[5], i_load_word_button = btn[6], i_repeat_button = btn[7],
    i_halt_button = btn[8], i_emergency_stop_button = btn[9], i_clear_error_button = btn[10],
    i_clear_machine_button = btn[11], i_clear_alarm_button = btn[12];
  logic [OCC_NUM_REGS-1:0]  i_reg_select_switch;
  logic [OCC_WORD_W-1:0]    i_reg_values [OCC_NUM_REGS];
  logic [OCC_ADDR_W-1:0]    i_address_switch_bank, pc;
  logic [OCC_WORD_W-1:0]    i_word_switch_bank, o_bus_display;
  occ_cpu_stat_t            i_cpu_stat, st;
  occ_cpu_req_t             o_cpu_req, lreq;
  logic [3:0]               i_alarm_loc_write, o_alarm_lamps;
  logic [15:0]              i_sense_ff, o_sense_ff_lamps_set, o_sense_ff_lamps_reset;
  logic [6:0]               i_special_ff, o_special_ff_lamps_set, o_special_ff_lamps_reset;
  logic o_cpu_timing_pulse, o_cpu_pulse_inhibit, o_cpu_skip_fetch, o_cpu_abort_io, done;
  logic o_clear_all_flops, o_bus_display_blank, o_sign_minus, o_parity_digit;
  logic o_bad_opcode_lamp, o_bad_memory_lamp, o_mem_parity_lamp, o_comm_parity_lamp;
  logic o_computing_lamp, o_non_computing_lamp;
  logic [7:0]               cnt;
  int                       failures, tests_run, nabort, nclr, npulse, n0;
  occ_console #(.NUM_BANKS(NB)) occ_console_i (.*);
  occ_cpu_model occ_cpu_model_i (.i_core_clk, .i_rst_n, .i_req(o_cpu_req),
    .i_computing(o_computing_lamp), .o_pc(pc), .o_instr_done(done), .o_count(cnt));
  always_comb begin
    i_cpu_stat = st;
    i_cpu_stat.pc = pc;
    i_cpu_stat.instr_done = done;
  end
  always @(posedge i_core_clk) begin
    if (o_cpu_req.valid) lreq <= o_cpu_req;
    if (o_cpu_abort_io) nabort++;
    if (o_clear_all_flops) nclr++;
    if (o_cpu_timing_pulse) npulse++;
  end
  initial begin
    i_core_clk = 0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task cmp(input logic [OCC_WORD_W-1:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task tick(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : tick
  // long enough to sync and re-arm
  task press(input int b);
    btn[b] = 1'b1;
    tick(6);
    btn[b] = 1'b0;
    tick(6);
  endtask : press
  task wait_halt;
    for (int n = 0; n < 200 && o_computing_lamp !== 1'b0; n++) tick(1);
  endtask : wait_halt
  task stop_test;
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task t_display;
    for (int k = 0; k <= 18; k++) begin
      i_reg_select_switch = 18'h1 << k;
      tick(8);
      cmp(o_bus_display, k < 18 ? {k[1:0], 30'h0, k[5:0]} : 38'h0);
      cmp(o_sign_minus, k < 18 && k[0]);
      cmp(o_parity_digit, k < 18 && k[1]);
      cmp(o_bus_display_blank, k == 18);
    end
  endtask : t_display
  task t_lamps;
    for (int e = 1; e >= 0; e--) begin
      st.opcode_valid = !e;
      st.bank_ext = 3'(NB - 1 + e);
      st.mem_out = e ? 38'h3 : 38'h1;
      st.comm_word = st.mem_out;
      st.comm_valid = 1'b1;
      tick(3);
      cmp({o_bad_opcode_lamp, o_bad_memory_lamp}, e ? 3 : 0);
      cmp({o_mem_parity_lamp, o_comm_parity_lamp}, e ? 3 : 0);
    end
    cmp({o_sense_ff_lamps_set, o_special_ff_lamps_reset}, 23'h52e1aa);
  endtask : t_lamps
  task t_alarms;
    for (int k = 0; k < 4; k++) begin
      i_alarm_loc_write = 4'h1 << k;
      tick(1);
      i_alarm_loc_write = 4'h0;
      tick(2);
      cmp(o_alarm_lamps, (2 << k) - 1);
    end
    press(12);
    cmp(o_alarm_lamps, 38'h0);
  endtask : t_alarms
  task t_cmds;
    for (int b = 0; b < 8; b++) begin
      lreq = '0;
      press(b);
      cmp(lreq.cmd, b + 1);
      if (b inside {0, 4, 6}) cmp(lreq.addr, i_address_switch_bank);
      if (b inside {5, 6}) cmp(lreq.word, i_word_switch_bank);
      if (b == 7) cmp(o_cpu_skip_fetch, 1);
      if (o_computing_lamp) press(8);
      wait_halt();
      cmp(o_non_computing_lamp, 1);
    end
    cmp(o_cpu_skip_fetch, 0);
  endtask : t_cmds
  task t_modes;
    i_address_match_stop_switch = 1'b1;
    i_address_switch_bank = pc + 18'h3;
    press(1);
    wait_halt();
    cmp(pc, i_address_switch_bank);
    i_address_match_stop_switch = 1'b0;
    i_one_instr_switch = 1'b1;
    n0 = cnt;
    press(1);
    wait_halt();
    cmp(cnt - n0, 1);
    i_run_switch = 1'b1;
    press(1);
    tick(20);
    cmp(o_computing_lamp, 1);
    st.prog_halt = 1'b1;
    tick(1);
    st.prog_halt = 1'b0;
    tick(2);
    cmp(o_computing_lamp, 0);
    i_one_instr_switch = 1'b0;
    i_run_switch = 1'b0;
  endtask : t_modes
  task t_stops;
    st.ext_error = 1'b1;
    press(1);
    tick(10);
    cmp(o_computing_lamp, 1);
    i_stop_on_error_select = 1'b1;
    tick(10);
    cmp(o_computing_lamp, 0);
    st.ext_error = 1'b0;
    press(1);
    st.io_active = 1'b1;
    n0 = nabort;
    press(9);
    cmp(nabort - n0, 1);
    cmp(o_computing_lamp, 0);
    st.io_active = 1'b0;
    for (int b = 10; b < 12; b++) begin
      press(1);
      n0 = nclr;
      press(b);
      cmp(nclr - n0, 1);
      cmp(o_computing_lamp, 0);
    end
  endtask : t_stops
  task t_single;
    i_single_pulse_switch = 1'b1;
    tick(6);
    cmp(o_cpu_pulse_inhibit, 1);
    n0 = npulse;
    press(1);
    cmp(npulse - n0, 1);
    i_run_switch = 1'b1;
    tick(6);
    cmp(o_cpu_pulse_inhibit, 0);
    press(8);
    wait_halt();
  endtask : t_single
  initial begin
    {i_rst_n, i_run_switch, i_one_instr_switch, i_single_pulse_switch} = '0;
    {i_address_match_stop_switch, i_stop_on_error_select, btn, i_reg_select_switch} = '0;
    {i_alarm_loc_write, failures, tests_run, nabort, nclr, npulse} = '0;
    {st, lreq} = '0;
    st.opcode_valid = 1'b1;
    st.mem_out = 38'h1;
    i_sense_ff = 16'ha5c3;
    i_special_ff = 7'h55;
    i_address_switch_bank = 18'h01234;
    i_word_switch_bank = 38'h2a_5a5a_a5a5;
    for (int k = 0; k < 18; k++) i_reg_values[k] = {k[1:0], 30'h0, k[5:0]};
    tick(10);
    i_rst_n = 1'b1;
    tick(4);
    t_display();
    t_lamps();
    t_alarms();
    t_cmds();
    t_modes();
    t_stops();
    t_single();
    stop_test();
  end
  initial begin
    #200000;
    failures++;
    stop_test();
  end
endmodule : occ_console_tb

// file: testbench/occ_cpu_model.sv
// behavioural processor stepping instructions for the console
`timescale 1ns/1ps
module occ_cpu_model
  import occ_pkg::*;
(
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  input  wire occ_cpu_req_t          i_req,
  input  wire logic                  i_computing,
  output logic      [OCC_ADDR_W-1:0] o_pc,
  output logic                       o_instr_done,
  output logic      [7:0]            o_count
);
  logic [1:0] phase_r;
  // four cycles each, so halts land mid-instruction
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_r      <= 2'h0;
      o_pc         <= '0;
      o_instr_done <= 1'b0;
      o_count      <= 8'h0;
    end else begin
      o_instr_done <= 1'b0;
      if (i_req.valid && i_req.cmd == OCC_CMD_START_ASR) begin
        o_pc <= i_req.addr;
      end else if (i_computing) begin
        phase_r <= phase_r + 2'h1;
        if (phase_r == 2'h3) begin
          o_instr_done <= 1'b1;
          o_pc         <= o_pc + 18'h1;
          o_count      <= o_count + 8'h1;
        end
      end
    end
  end
endmodule : occ_cpu_model
